// ==== sfp_flash_frontend.sv ====
// Overview of operation
// - Complement on, small unit off: protected area is inverse of normal range.
// - Complement with small unit: range bits 1 to 5 leave only a 4KB to 32KB end slice free.
// - Erase or program touching any protected byte is dropped.
// - Block lock bits count only with lock scheme select set.
// - All block lock bits come up set after reset.
// - Chip select fall starts an instruction; first byte is opcode.
// - Single line: sample rising edge, most significant bit first.
// - Four wire mode: nibble per edge, high nibble first, all bytes.
// - Instruction is opcode plus optional bytes, ends at chip select rise.
// - Reads may end after any bit without error.
// - Write, program, erase act only when ended on a byte boundary.
// - While engine busy, only status reads are served.
// - Maker code plus 8-bit or 16-bit device code by opcode.
// - Four wire entry needs quad enable, else ignored.
// - Lock scheme select set: block locks replace range bits.
`timescale 1ns/1ps
module sfp_flash_frontend #(
  parameter logic [7:0]  MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0]  DEV_CODE8  = 8'h3c, // Arbitrary value
  parameter logic [15:0] DEV_CODE16 = 16'h7a18 // Arbitrary value
) (
  input  wire logic           ref_clk,
  input  wire logic           srst,
  input  wire logic           link_clk,
  input  wire logic           cs_n,
  input  wire logic [3:0]     io_in,
  output logic      [3:0]     io_out,
  output logic      [3:0]     io_oe,
  input  wire logic           complement_protect,
  input  wire logic           lock_scheme_select,
  input  wire logic           small_unit_select,
  input  wire logic           top_bottom_select,
  input  wire logic           protect_range_bit2,
  input  wire logic           protect_range_bit1,
  input  wire logic           protect_range_bit0,
  input  wire logic           quad_io_enable,
  input  wire logic           engine_busy,
  output logic                op_start,
  output logic                op_reject,
  output sfp_pkg::sfp_op_t    op_kind,
  output logic      [23:0]    op_addr,
  output logic      [7:0]     wr_data,
  output logic                wr_valid,
  output logic                four_wire_command_mode,
  output logic                write_enabled
);
  typedef enum {ST_IDLE, ST_ACTIVE, ST_DISCARD} sfp_state_t;

  logic [3:0] smp_ff;
  logic       tog_ff;
  logic       cs_meta_ff, cs_sync_ff, cs_prev_ff;
  logic       tg_meta_ff, tg_sync_ff, tg_prev_ff;
  logic       cs_fall, cs_rise, edge_evt;

  sfp_state_t       state_ff, nxt_state;
  logic [2:0]       bit_cnt_ff, nxt_bit_cnt;
  logic [3:0]       byte_cnt_ff, nxt_byte_cnt;
  logic [7:0]       shift_ff, nxt_shift;
  logic [7:0]       opcode_ff, nxt_opcode;
  logic [23:0]      addr_ff, nxt_addr;
  logic             quad_ff, nxt_quad;
  logic             wel_ff, nxt_wel;
  logic [31:0]      lock_ff, nxt_lock;
  logic [3:0]       drv_nib_ff, nxt_drv_nib;
  logic [3:0]       drv_en_ff, nxt_drv_en;
  logic             op_start_ff, nxt_op_start;
  logic             op_reject_ff, nxt_op_reject;
  sfp_pkg::sfp_op_t op_kind_ff, nxt_op_kind;
  logic [23:0]      op_addr_ff, nxt_op_addr;
  logic [7:0]       wr_data_ff, nxt_wr_data;
  logic             wr_valid_ff, nxt_wr_valid;

  logic [2:0]       range_bits;
  logic             array_cmd, enough_bytes, region_prot;
  logic             range_prot, block_prot;
  sfp_pkg::sfp_op_t region_kind;
  logic [21:0]      reg_mask, reg_s, reg_e;

  assign range_bits = {protect_range_bit2, protect_range_bit1,
                       protect_range_bit0};

  // Size of the normal protected range
  function automatic logic [21:0] norm_size(input logic slice,
                                            input logic [2:0] bp);
    logic [21:0] sz;
    sz = 22'h0;
    if (bp == 3'h0)
      sz = 22'h0;
    else if (bp[2:1] == 2'h3)
      sz = sfp_pkg::ARRAY_BYTES;
    else if (!slice)
      sz = sfp_pkg::BLOCK_BYTES << (bp - 3'h1);
    else if (bp[2])
      sz = sfp_pkg::HALF_BLOCK;
    else
      sz = sfp_pkg::SECTOR_BYTES << (bp - 3'h1);
    return sz;
  endfunction : norm_size

  // Region [s,e] overlaps range-bit protection; areas are end-anchored
  function automatic logic range_hit(input logic [21:0] s,
                                     input logic [21:0] e,
                                     input logic inv, input logic slice,
                                     input logic top,
                                     input logic [2:0] bp);
    logic [21:0] sz;
    logic        hit;
    sz = norm_size(slice, bp);
    if (!inv)
      hit = top ? (s < sz) : (e >= sfp_pkg::ARRAY_BYTES - sz);
    else
      hit = top ? (e >= sz) : (s < sfp_pkg::ARRAY_BYTES - sz);
    return hit;
  endfunction : range_hit

  // Any locked block overlapping the region
  function automatic logic block_hit(input logic [21:0] s,
                                     input logic [21:0] e,
                                     input logic [31:0] lk);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < sfp_pkg::NUM_BLOCKS; i++)
      if (lk[i] && (i >= int'(s >> sfp_pkg::BLOCK_SHIFT)) &&
          (i <= int'(e >> sfp_pkg::BLOCK_SHIFT)))
        hit = 1'b1;
    return hit;
  endfunction : block_hit

  // Answer byte for an opcode at a byte index, bit 8 marks valid
  function automatic logic [8:0] resp(input logic [7:0] op,
                                      input logic [3:0] idx,
                                      input logic busy, input logic wel);
    logic [8:0] r;
    r = 9'h0;
    case (op)
      sfp_pkg::OP_RD_STAT:
        if (idx != 4'h0) r = {1'b1, 6'h0, wel, busy};
      sfp_pkg::OP_ID16:
        case (idx)
          4'h1:    r = {1'b1, MAKER_CODE};
          4'h2:    r = {1'b1, DEV_CODE16[15:8]};
          4'h3:    r = {1'b1, DEV_CODE16[7:0]};
          default: r = 9'h0;
        endcase
      sfp_pkg::OP_ID_WAKE:
        if (idx >= sfp_pkg::ID_FIRST) r = {1'b1, DEV_CODE8};
      sfp_pkg::OP_ID_PAIR, sfp_pkg::OP_ID_PAIR2, sfp_pkg::OP_ID_PAIR4:
        if (idx >= sfp_pkg::ID_FIRST)
          r = {1'b1, idx[0] ? DEV_CODE8 : MAKER_CODE};
      default: r = 9'h0;
    endcase
    return r;
  endfunction : resp

  sfp_link_cap u_link (
    .link_clk (link_clk),
    .srst     (srst),
    .cs_n     (cs_n),
    .io_in    (io_in),
    .drv_nib  (drv_nib_ff),
    .drv_en   (drv_en_ff),
    .smp_ff   (smp_ff),
    .tog_ff   (tog_ff),
    .io_out   (io_out),
    .io_oe    (io_oe)
  );

  // Two-flop synchronisers for chip select and edge toggle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      tg_meta_ff <= 1'b0;
      tg_sync_ff <= 1'b0;
      tg_prev_ff <= 1'b0;
    end else begin
      cs_meta_ff <= cs_n;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      tg_meta_ff <= tog_ff;
      tg_sync_ff <= tg_meta_ff;
      tg_prev_ff <= tg_sync_ff;
    end
  end

  assign cs_fall  = cs_prev_ff & ~cs_sync_ff;
  assign cs_rise  = ~cs_prev_ff & cs_sync_ff;
  assign edge_evt = tg_sync_ff ^ tg_prev_ff;

  // Target region of the captured command
  always_comb begin
    array_cmd    = 1'b1;
    enough_bytes = byte_cnt_ff >= sfp_pkg::ADDR_DONE;
    region_kind  = sfp_pkg::OPK_SECTOR;
    reg_mask     = sfp_pkg::SECTOR_BYTES - 22'h1;
    case (opcode_ff)
      sfp_pkg::OP_ERASE_4K: ;
      sfp_pkg::OP_ERASE_32K: begin
        region_kind = sfp_pkg::OPK_BLK32;
        reg_mask    = sfp_pkg::HALF_BLOCK - 22'h1;
      end
      sfp_pkg::OP_ERASE_64K: begin
        region_kind = sfp_pkg::OPK_BLK64;
        reg_mask    = sfp_pkg::BLOCK_BYTES - 22'h1;
      end
      sfp_pkg::OP_CHIP_A, sfp_pkg::OP_CHIP_B: begin
        region_kind  = sfp_pkg::OPK_CHIP;
        reg_mask     = sfp_pkg::ARRAY_BYTES - 22'h1;
        enough_bytes = 1'b1;
      end
      sfp_pkg::OP_PROG, sfp_pkg::OP_PROG4: begin
        region_kind  = sfp_pkg::OPK_PROG;
        reg_mask     = sfp_pkg::PAGE_BYTES - 22'h1;
        enough_bytes = byte_cnt_ff >= sfp_pkg::PROG_MIN;
      end
      default: array_cmd = 1'b0;
    endcase
    reg_s = {1'b0, addr_ff[sfp_pkg::ARRAY_AW-1:0]} & ~reg_mask;
    reg_e = reg_s | reg_mask;
    range_prot  = range_hit(reg_s, reg_e, complement_protect,
                            small_unit_select, top_bottom_select,
                            range_bits);
    block_prot  = block_hit(reg_s, reg_e, lock_ff);
    region_prot = lock_scheme_select ? block_prot : range_prot;
  end

  // Framing, answer launch and commit at frame end
  always_comb begin
    logic [7:0] new_byte;
    logic       last;
    logic [3:0] nidx;
    logic [2:0] npos;
    logic [7:0] op_e;
    logic [8:0] r;
    new_byte = quad_ff ? {shift_ff[3:0], smp_ff}
                       : {shift_ff[6:0], smp_ff[0]};
    last = bit_cnt_ff == (quad_ff ? sfp_pkg::QUAD_LAST
                                  : sfp_pkg::SPI_LAST);
    nidx = (last && byte_cnt_ff != sfp_pkg::BYTE_SAT) ?
           byte_cnt_ff + 4'h1 : byte_cnt_ff;
    npos = last ? 3'h0 : bit_cnt_ff + 3'h1;
    op_e = (byte_cnt_ff == 4'h0) ? new_byte : opcode_ff;
    r    = resp(op_e, nidx, engine_busy, wel_ff);
    nxt_state     = state_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_byte_cnt  = byte_cnt_ff;
    nxt_shift     = shift_ff;
    nxt_opcode    = opcode_ff;
    nxt_addr      = addr_ff;
    nxt_quad      = quad_ff;
    nxt_wel       = wel_ff;
    nxt_lock      = lock_ff;
    nxt_drv_nib   = drv_nib_ff;
    nxt_drv_en    = drv_en_ff;
    nxt_op_start  = 1'b0;
    nxt_op_reject = 1'b0;
    nxt_op_kind   = op_kind_ff;
    nxt_op_addr   = op_addr_ff;
    nxt_wr_data   = wr_data_ff;
    nxt_wr_valid  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cs_fall) begin
          nxt_state    = ST_ACTIVE;
          nxt_bit_cnt  = 3'h0;
          nxt_byte_cnt = 4'h0;
          nxt_drv_en   = 4'h0;
        end
      end
      ST_ACTIVE, ST_DISCARD: begin
        if (cs_rise) begin
          nxt_state  = ST_IDLE;
          nxt_drv_en = 4'h0;
          if (state_ff == ST_ACTIVE && bit_cnt_ff == 3'h0 &&
              byte_cnt_ff != 4'h0) begin
            case (opcode_ff)
              sfp_pkg::OP_WR_ON:  nxt_wel = 1'b1;
              sfp_pkg::OP_WR_OFF: nxt_wel = 1'b0;
              sfp_pkg::OP_FOUR_ON:
                if (quad_io_enable) nxt_quad = 1'b1;
              sfp_pkg::OP_FOUR_OFF: nxt_quad = 1'b0;
              sfp_pkg::OP_LOCK_ALL, sfp_pkg::OP_FREE_ALL:
                if (wel_ff) begin
                  nxt_lock = (opcode_ff == sfp_pkg::OP_LOCK_ALL) ?
                             sfp_pkg::LOCK_RST : 32'h0;
                  nxt_wel  = 1'b0;
                end
              sfp_pkg::OP_LOCK_ONE, sfp_pkg::OP_FREE_ONE:
                if (wel_ff && enough_bytes) begin
                  nxt_lock[addr_ff[20:16]] =
                    (opcode_ff == sfp_pkg::OP_LOCK_ONE);
                  nxt_wel = 1'b0;
                end
              default:
                if (array_cmd && wel_ff && enough_bytes) begin
                  nxt_op_reject = region_prot;
                  nxt_op_start  = ~region_prot;
                  nxt_op_kind   = region_kind;
                  nxt_op_addr   = addr_ff;
                  nxt_wel       = 1'b0;
                end
            endcase
          end
        end else if (edge_evt) begin
          nxt_shift   = new_byte;
          nxt_bit_cnt = npos;
          if (last) begin
            nxt_byte_cnt = nidx;
            if (byte_cnt_ff == 4'h0) begin
              nxt_opcode = new_byte;
              if (engine_busy && new_byte != sfp_pkg::OP_RD_STAT)
                nxt_state = ST_DISCARD;
            end else if (byte_cnt_ff < sfp_pkg::DATA_FIRST)
              nxt_addr = {addr_ff[15:0], new_byte};
            else if (opcode_ff == sfp_pkg::OP_PROG ||
                     opcode_ff == sfp_pkg::OP_PROG4) begin
              nxt_wr_data  = new_byte;
              nxt_wr_valid = (state_ff == ST_ACTIVE);
            end
          end
          if (quad_ff) begin
            nxt_drv_nib = (npos == 3'h0) ? r[7:4] : r[3:0];
            nxt_drv_en  = {4{r[8]}};
          end else begin
            nxt_drv_nib = {2'h0, r[3'h7 - npos], 1'b0};
            nxt_drv_en  = {2'h0, r[8], 1'b0};
          end
          if (nxt_state == ST_DISCARD)
            nxt_drv_en = 4'h0;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff     <= ST_IDLE;
      bit_cnt_ff   <= 3'h0;
      byte_cnt_ff  <= 4'h0;
      shift_ff     <= 8'h0;
      opcode_ff    <= 8'h0;
      addr_ff      <= 24'h0;
      quad_ff      <= 1'b0;
      wel_ff       <= 1'b0;
      lock_ff      <= sfp_pkg::LOCK_RST;
      drv_nib_ff   <= 4'h0;
      drv_en_ff    <= 4'h0;
      op_start_ff  <= 1'b0;
      op_reject_ff <= 1'b0;
      op_kind_ff   <= sfp_pkg::OPK_SECTOR;
      op_addr_ff   <= 24'h0;
      wr_data_ff   <= 8'h0;
      wr_valid_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      bit_cnt_ff   <= nxt_bit_cnt;
      byte_cnt_ff  <= nxt_byte_cnt;
      shift_ff     <= nxt_shift;
      opcode_ff    <= nxt_opcode;
      addr_ff      <= nxt_addr;
      quad_ff      <= nxt_quad;
      wel_ff       <= nxt_wel;
      lock_ff      <= nxt_lock;
      drv_nib_ff   <= nxt_drv_nib;
      drv_en_ff    <= nxt_drv_en;
      op_start_ff  <= nxt_op_start;
      op_reject_ff <= nxt_op_reject;
      op_kind_ff   <= nxt_op_kind;
      op_addr_ff   <= nxt_op_addr;
      wr_data_ff   <= nxt_wr_data;
      wr_valid_ff  <= nxt_wr_valid;
    end
  end

  assign op_start               = op_start_ff;
  assign op_reject              = op_reject_ff;
  assign op_kind                = op_kind_ff;
  assign op_addr                = op_addr_ff;
  assign wr_data                = wr_data_ff;
  assign wr_valid               = wr_valid_ff;
  assign four_wire_command_mode = quad_ff;
  assign write_enabled          = wel_ff;

  // Checks
  sequence s_frame_end;
    cs_rise && state_ff == ST_ACTIVE;
  endsequence

  sequence s_armed_array;
    s_frame_end ##0 (array_cmd && wel_ff && enough_bytes &&
                     bit_cnt_ff == 3'h0 && byte_cnt_ff != 4'h0);
  endsequence

  chk_protect_drop: assert property (@(posedge ref_clk) disable iff (srst)
    s_armed_array ##0 region_prot |=> op_reject_ff && !op_start_ff)
    else $error("protected command was not dropped");

  chk_start_clean: assert property (@(posedge ref_clk) disable iff (srst)
    op_start_ff |-> !$past(region_prot) && op_addr_ff == $past(addr_ff))
    else $error("array start on protected region");

  chk_scheme_sel: assert property (@(posedge ref_clk) disable iff (srst)
    s_armed_array ##0 (lock_scheme_select && lock_ff == 32'h0)
    |=> op_start_ff)
    else $error("range bits used under block lock scheme");

  chk_lock_reset: assert property (@(posedge ref_clk)
    $past(srst) |-> lock_ff == 32'hffffffff)
    else $error("lock bits not all set after reset");

  chk_cmp_lower: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |-> range_hit(22'h1effff, 22'h1effff, 1'b1, 1'b0, 1'b0, 3'h1)
      && !range_hit(22'h1f0000, 22'h1f0000, 1'b1, 1'b0, 1'b0, 3'h1)
      && !range_hit(22'h00ffff, 22'h00ffff, 1'b1, 1'b0, 1'b1, 3'h1))
    else $error("complement range wrong");

  chk_small_slice: assert property (@(posedge ref_clk) disable iff (srst)
    1'b1 |-> !range_hit(22'h0, 22'h000fff, 1'b1, 1'b1, 1'b1, 3'h1)
      && range_hit(22'h001000, 22'h001000, 1'b1, 1'b1, 1'b1, 3'h1)
      && !range_hit(22'h1f8000, 22'h1f8000, 1'b1, 1'b1, 1'b0, 3'h5))
    else $error("small unit slice wrong");

  chk_byte_align: assert property (@(posedge ref_clk) disable iff (srst)
    s_frame_end ##0 bit_cnt_ff != 3'h0
    |=> !op_start_ff && !op_reject_ff && $stable(wel_ff) &&
        $stable(lock_ff) && $stable(quad_ff))
    else $error("unaligned frame took effect");

  chk_busy_gate: assert property (@(posedge ref_clk) disable iff (srst)
    state_ff == ST_ACTIVE && edge_evt && !cs_rise && byte_cnt_ff == 4'h0
    && bit_cnt_ff == (quad_ff ? 3'h1 : 3'h7) && engine_busy
    && nxt_opcode != 8'h05 |=> state_ff == ST_DISCARD ##1 drv_en_ff == 4'h0)
    else $error("busy device served a command");

  chk_quad_gate: assert property (@(posedge ref_clk) disable iff (srst)
    s_frame_end ##0 (opcode_ff == 8'h38 && !quad_io_enable && !quad_ff)
    |=> !quad_ff [*2])
    else $error("four wire entry without quad enable");

  chk_frame_open: assert property (@(posedge ref_clk) disable iff (srst)
    state_ff == ST_IDLE && cs_fall |=> state_ff == ST_ACTIVE &&
    byte_cnt_ff == 4'h0 && bit_cnt_ff == 3'h0 && drv_en_ff == 4'h0)
    else $error("frame did not open cleanly");
endmodule : sfp_flash_frontend

// ==== sfp_pkg.sv ====
package sfp_pkg;
  // Array geometry
  localparam int          ARRAY_AW     = 21;
  localparam int          NUM_BLOCKS   = 32;
  localparam int          BLOCK_SHIFT  = 16;
  localparam logic [21:0] ARRAY_BYTES  = 22'h200000;
  localparam logic [21:0] BLOCK_BYTES  = 22'h010000;
  localparam logic [21:0] HALF_BLOCK   = 22'h008000;
  localparam logic [21:0] SECTOR_BYTES = 22'h001000;
  localparam logic [21:0] PAGE_BYTES   = 22'h000100;
  localparam logic [31:0] LOCK_RST     = 32'hffffffff;

  // Framing counts
  localparam logic [2:0]  SPI_LAST     = 3'h7;
  localparam logic [2:0]  QUAD_LAST    = 3'h1;
  localparam logic [3:0]  BYTE_SAT     = 4'hf;
  localparam logic [3:0]  ADDR_DONE    = 4'h4;
  localparam logic [3:0]  DATA_FIRST   = 4'h4;
  localparam logic [3:0]  PROG_MIN     = 4'h5;
  localparam logic [3:0]  ID_FIRST     = 4'h4;

  // Opcodes
  localparam logic [7:0]  OP_WR_ON     = 8'h06;
  localparam logic [7:0]  OP_WR_OFF    = 8'h04;
  localparam logic [7:0]  OP_RD_STAT   = 8'h05;
  localparam logic [7:0]  OP_ID16      = 8'h9f;
  localparam logic [7:0]  OP_ID_WAKE   = 8'hab;
  localparam logic [7:0]  OP_ID_PAIR   = 8'h90;
  localparam logic [7:0]  OP_ID_PAIR2  = 8'h92;
  localparam logic [7:0]  OP_ID_PAIR4  = 8'h94;
  localparam logic [7:0]  OP_FOUR_ON   = 8'h38;
  localparam logic [7:0]  OP_FOUR_OFF  = 8'hff;
  localparam logic [7:0]  OP_LOCK_ALL  = 8'h7e;
  localparam logic [7:0]  OP_FREE_ALL  = 8'h98;
  localparam logic [7:0]  OP_LOCK_ONE  = 8'h36;
  localparam logic [7:0]  OP_FREE_ONE  = 8'h39;
  localparam logic [7:0]  OP_ERASE_4K  = 8'h20;
  localparam logic [7:0]  OP_ERASE_32K = 8'h52;
  localparam logic [7:0]  OP_ERASE_64K = 8'hd8;
  localparam logic [7:0]  OP_CHIP_A    = 8'hc7;
  localparam logic [7:0]  OP_CHIP_B    = 8'h60;
  localparam logic [7:0]  OP_PROG      = 8'h02;
  localparam logic [7:0]  OP_PROG4     = 8'h32;

  typedef enum logic [2:0] {
    OPK_SECTOR, OPK_BLK32, OPK_BLK64, OPK_CHIP, OPK_PROG
  } sfp_op_t;
endpackage : sfp_pkg

// ==== sfp_link_cap.sv ====
`timescale 1ns/1ps
module sfp_link_cap (
  input  wire logic       link_clk,
  input  wire logic       srst,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  input  wire logic [3:0] drv_nib,
  input  wire logic [3:0] drv_en,
  output logic      [3:0] smp_ff,
  output logic            tog_ff,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe
);
  logic [3:0] nxt_smp;
  logic       nxt_tog;
  logic [3:0] io_out_ff;
  logic [3:0] io_oe_ff;
  logic [3:0] nxt_io_out;
  logic [3:0] nxt_io_oe;

  // Sample all lanes on rising edge, flag each edge by a toggle
  always_comb begin
    nxt_smp = smp_ff;
    nxt_tog = tog_ff;
    if (!cs_n) begin
      nxt_smp = io_in;
      nxt_tog = ~tog_ff;
    end
  end

  always_ff @(posedge link_clk or posedge srst) begin
    if (srst) begin
      smp_ff <= 4'h0;
      tog_ff <= 1'b0;
    end else begin
      smp_ff <= nxt_smp;
      tog_ff <= nxt_tog;
    end
  end

  // Launch answer on falling edge; chip select high releases lanes
  always_comb begin
    nxt_io_out = drv_nib;
    nxt_io_oe  = drv_en;
  end

  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      io_out_ff <= 4'h0;
      io_oe_ff  <= 4'h0;
    end else begin
      io_out_ff <= nxt_io_out;
      io_oe_ff  <= nxt_io_oe;
    end
  end

  assign io_out = io_out_ff;
  assign io_oe  = io_oe_ff;
endmodule : sfp_link_cap

// ==== sfp_host_model.sv ====
`timescale 1ns/1ps
module sfp_host_model (
  output logic            cs_n,
  output logic            link_clk,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  // Deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    link_clk = 1'b0;
    io_in = 4'h0;
  end
  // One frame, opcode first, answer taken at each rise
  task automatic frame(input logic [63:0] b, input int n, input bit q,
                       output logic [31:0] rd);
    rd = 32'h0;
    #3 cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      io_in = q ? b[63:60] : {~io_in[3:1], b[63]};
      b = q ? b << 4 : b << 1;
      #40 link_clk = 1'b1;
      // Released answer lane reads as the inverse
      rd = {rd[30:0], io_oe[1] ? io_out[1] : ~io_out[1]};
      #40 link_clk = 1'b0;
    end
    #40 cs_n = 1'b1;
    io_in = ~io_in; // Released lanes lose last value
    #60;
  endtask : frame
endmodule : sfp_host_model

// ==== serial_flash_protect_and_frame_tb_top.sv ====
`timescale 1ns/1ps
module serial_flash_protect_and_frame_tb_top;
  localparam logic [7:0]  MK  = 8'h5a; // Arbitrary value
  localparam logic [7:0]  D8  = 8'h3c; // Arbitrary value
  localparam logic [15:0] D16 = 16'h7a18; // Arbitrary value
  logic             ref_clk, srst, cs_n, link_clk;
  logic [3:0]       io_in, io_out, io_oe;
  logic             cpl, lss, sus, tbs, qen, busy, ex;
  logic [2:0]       bp;
  logic [7:0]       op, wd;
  logic [20:0]      m;
  logic             op_start, op_reject, wr_valid, qm, wel;
  sfp_pkg::sfp_op_t op_kind;
  logic [23:0]      op_addr, a;
  logic [7:0]       wr_data;
  logic [31:0]      seed, rd;
  int               errors, n_compared, n_st, n_rj, s0, r0, n_wr, w0;
  // Core clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  sfp_flash_frontend #(.MAKER_CODE(MK), .DEV_CODE8(D8), .DEV_CODE16(D16))
    sfp_flash_frontend_inst (.ref_clk(ref_clk), .srst(srst),
    .link_clk(link_clk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .complement_protect(cpl), .lock_scheme_select(lss),
    .small_unit_select(sus), .top_bottom_select(tbs),
    .protect_range_bit2(bp[2]), .protect_range_bit1(bp[1]),
    .protect_range_bit0(bp[0]), .quad_io_enable(qen), .engine_busy(busy),
    .op_start(op_start), .op_reject(op_reject), .op_kind(op_kind),
    .op_addr(op_addr), .wr_data(wr_data), .wr_valid(wr_valid),
    .four_wire_command_mode(qm), .write_enabled(wel));
  sfp_host_model sfp_host_model_inst (.cs_n(cs_n), .link_clk(link_clk),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  // Count start and reject pulses
  always @(posedge ref_clk) begin
    if (op_start === 1'b1) n_st++;
    if (op_reject === 1'b1) n_rj++;
    if (wr_valid === 1'b1) begin
      n_wr++;
      wd <= wr_data;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Byte protected under range bits, c = {complement, unit, top, range}
  function automatic bit pr(input logic [20:0] x, input logic [5:0] c);
    logic [21:0] sz;
    bit          hit;
    if (c[2:0] == 3'h0) hit = 1'b0;
    else if (c[2:1] == 2'b11) hit = 1'b1;
    else begin
      sz = c[4] ? (sfp_pkg::SECTOR_BYTES << ((c[2:0] > 3'h4 ? 3'h4 : c[2:0])
           - 3'h1)) : (sfp_pkg::BLOCK_BYTES << (c[2:0] - 3'h1));
      hit = c[3] ? ({1'b0, x} < sz) : ({1'b0, x} >= sfp_pkg::ARRAY_BYTES - sz);
    end
    return hit ^ c[5];
  endfunction : pr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg(input logic [8:0] c);
    @(posedge ref_clk);
    {busy, qen, lss, cpl, sus, tbs, bp} <= c;
  endtask : cfg
  task automatic run(input logic [7:0] op, input logic [23:0] ad,
                     input int n, input bit q);
    s0 = n_st;
    r0 = n_rj;
    sfp_host_model_inst.frame({op, ad, 32'h0}, n, q, rd);
    repeat (12) @(posedge ref_clk);
  endtask : run
  task automatic erase(input logic [23:0] ad, input bit q);
    run(8'h06, 24'h0, q ? 2 : 8, q);
    run(8'h20, ad, q ? 8 : 32, q);
  endtask : erase
  task automatic test_done;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    #600000;
    errors++;
    test_done;
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    seed = 32'h945a14d4;
    {busy, qen, lss, cpl, sus, tbs, bp} = 9'h0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({qm, wel}, 32'h0);
    cfg(9'h040);
    erase(24'h012000, 1'b0);
    chk(n_rj - r0, 1);
    run(8'h06, 24'h0, 8, 1'b0);
    run(8'h98, 24'h0, 8, 1'b0);
    erase(24'h012000, 1'b0);
    chk(n_st - s0, 1);
    run(8'h06, 24'h0, 8, 1'b0);
    run(8'h36, 24'h010000, 32, 1'b0);
    erase(24'h01f000, 1'b0);
    chk(n_rj - r0, 1);
    run(8'h06, 24'h0, 8, 1'b0);
    run(8'h7e, 24'h0, 8, 1'b0);
    cfg(9'h000);
    erase(24'h1ff000, 1'b0);
    chk(n_st - s0, 1);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = i == 0 ? 24'h1ef000 : i == 1 ? 24'h1f0000 : seed[31:8];
      cfg(i < 2 ? 9'h021 : {3'h0, seed[5:0]});
      op = seed[7] ? 8'hd8 : seed[6] ? 8'h52 : 8'h20;
      m  = seed[7] ? 21'h00ffff : seed[6] ? 21'h007fff : 21'h000fff;
      @(posedge ref_clk);
      ex = pr(a[20:0] & ~m, {cpl, sus, tbs, bp})
         | pr(a[20:0] | m, {cpl, sus, tbs, bp});
      run(8'h06, 24'h0, 8, 1'b0);
      run(op, a, 32, 1'b0);
      chk(n_rj - r0, ex);
      chk(n_st - s0, !ex);
    end
    cfg(9'h000);
    run(8'h06, 24'h0, 8, 1'b0);
    run(8'h20, 24'h0, 31, 1'b0);
    chk(n_st - s0, 0);
    run(8'h06, 24'h0, 8, 1'b0);
    seed = lfsr(seed);
    w0 = n_wr;
    s0 = n_st;
    sfp_host_model_inst.frame({8'h02, seed, 24'h0}, 40, 1'b0, rd);
    repeat (12) @(posedge ref_clk);
    chk(n_wr - w0, 1);
    chk(wd, seed[7:0]);
    chk(n_st - s0, 1);
    chk(op_kind, sfp_pkg::OPK_PROG);
    cfg(9'h100);
    run(8'h06, 24'h0, 8, 1'b0);
    chk(wel, 0);
    run(8'h05, 24'h0, 16, 1'b0);
    chk(rd[7:0], 8'h01);
    cfg(9'h000);
    run(8'h9f, 24'h0, 13, 1'b0);
    chk(rd[4:0], MK[7:3]);
    run(8'h9f, 24'h0, 32, 1'b0);
    chk(rd[23:0], {MK, D16});
    run(8'hab, 24'h0, 40, 1'b0);
    chk(rd[7:0], D8);
    run(8'h90, 24'h0, 48, 1'b0);
    chk(rd[15:0], {MK, D8});
    run(8'h38, 24'h0, 8, 1'b0);
    chk(qm, 0);
    cfg(9'h080);
    run(8'h38, 24'h0, 8, 1'b0);
    chk(qm, 1);
    erase(24'h100000, 1'b1);
    chk(n_st - s0, 1);
    chk(op_addr, 24'h100000);
    chk(op_kind, sfp_pkg::OPK_SECTOR);
    run(8'hff, 24'h0, 2, 1'b1);
    chk(qm, 0);
    test_done;
  end
endmodule : serial_flash_protect_and_frame_tb_top
